// File: hw/watchdog_defines.vh
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH
// =====================================
// register addresses in host i/o space
`define ADDR_TIME_BASE_SELECT 16'h0a65
`define ADDR_TIMEOUT_INTERVAL 16'h0a66
`define ADDR_RESTART_SOURCE_CONFIG 16'h0a67
`define ADDR_TIMER_CONTROL_STATUS 16'h0a68
// =====================================
// field positions
`define TB_SECONDS_BIT 7
`define CFG_KBD_RESTART_BIT 1
`define CFG_MOUSE_RESTART_BIT 2
`define CTRL_EXPIRED_BIT 0
`define CTRL_FORCE_BIT 2
`define CTRL_KBD_END_BIT 3
// =====================================
// reset values
`define TIME_BASE_RESET 8'h00
`define INTERVAL_RESET 8'h00
`define CONFIG_RESET 8'h00
`define CONTROL_RESET 8'h00
// =====================================
// timing
// clock cycles per second at 10 mhz
`define SECOND_CYCLES 24'h98_9680
`define SECONDS_PER_MINUTE 6'h3c
`define RESET_PULSE_CYCLES 5'h10
`endif

// File: hw/tick_divider.v
`include "watchdog_defines.vh"
module tick_divider #(
  parameter [23:0] SECOND_CYCLES = `SECOND_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire restart,
  output reg second_tick,
  output reg minute_tick
);
  reg [23:0] cycle_reg;
  reg [5:0] second_reg;
  // =====================================
  // one-second and one-minute ticks
  always @(posedge clock) begin
    if (rst || restart) begin
      cycle_reg <= 24'h00_0000;
      second_reg <= 6'h00;
      second_tick <= 1'b0;
      minute_tick <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      minute_tick <= 1'b0;
      if (cycle_reg == SECOND_CYCLES - 24'h00_0001) begin
        cycle_reg <= 24'h00_0000;
        second_tick <= 1'b1;
        if (second_reg == `SECONDS_PER_MINUTE - 6'h01) begin
          second_reg <= 6'h00;
          minute_tick <= 1'b1;
        end else begin
          second_reg <= second_reg + 6'h01;
        end
      end else begin
        cycle_reg <= cycle_reg + 24'h00_0001;
      end
    end
  end
endmodule

// File: hw/input_sync.v
module input_sync (
  input wire clock,
  input wire rst,
  input wire async_in,
  output reg sync_out
);
  reg meta_reg;
  // =====================================
  // two-stage synchroniser
  always @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: hw/programmable_watchdog.v
`include "watchdog_defines.vh"
module programmable_watchdog #(
  parameter [23:0] SECOND_CYCLES = `SECOND_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_write,
  input wire io_read,
  output reg [7:0] io_rdata,
  output reg io_hit,
  input wire kbd_irq,
  input wire mouse_irq,
  input wire key_press,
  output reg system_reset_out,
  output wire expired
);
  localparam ST_IDLE = 3'b001;
  localparam ST_COUNT = 3'b010;
  localparam ST_EXPIRED = 3'b100;

  reg [2:0] state_reg;
  reg [7:0] time_base_reg;
  reg [7:0] interval_reg;
  reg [7:0] config_reg;
  reg key_end_en_reg;
  reg expired_reg;
  reg [7:0] count_reg;
  reg [4:0] pulse_reg;
  reg [2:0] pin_prev_reg;

  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  wire second_tick;
  wire minute_tick;
  wire unit_tick;
  wire kbd_edge;
  wire mouse_edge;
  wire key_edge;
  wire restart;
  wire force_end;
  wire key_end;
  wire wr_tb;
  wire wr_iv;
  wire wr_cfg;
  wire wr_ctrl;

  // =====================================
  // input synchronisers, one per event pin
  assign pin_raw = {key_press, mouse_irq, kbd_irq};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      input_sync input_sync_i (
        .clock(clock),
        .rst(rst),
        .async_in(pin_raw[gi]),
        .sync_out(pin_sync[gi])
      );
    end
  endgenerate

  always @(posedge clock) begin
    if (rst) begin
      pin_prev_reg <= 3'b000;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  // rising edges only, pins idle low
  assign kbd_edge = pin_sync[0] & ~pin_prev_reg[0];
  assign mouse_edge = pin_sync[1] & ~pin_prev_reg[1];
  assign key_edge = pin_sync[2] & ~pin_prev_reg[2];

  // =====================================
  // register decode
  assign wr_tb = io_write && (io_addr == `ADDR_TIME_BASE_SELECT);
  assign wr_iv = io_write && (io_addr == `ADDR_TIMEOUT_INTERVAL);
  assign wr_cfg = io_write && (io_addr == `ADDR_RESTART_SOURCE_CONFIG);
  assign wr_ctrl = io_write && (io_addr == `ADDR_TIMER_CONTROL_STATUS);

  assign restart = (config_reg[`CFG_KBD_RESTART_BIT] && kbd_edge) ||
    (config_reg[`CFG_MOUSE_RESTART_BIT] && mouse_edge);
  assign force_end = wr_ctrl && io_wdata[`CTRL_FORCE_BIT];
  assign key_end = key_end_en_reg && key_edge;

  // =====================================
  // time base ticks
  tick_divider #(
    .SECOND_CYCLES(SECOND_CYCLES)
  ) divider (
    .clock(clock),
    .rst(rst),
    .restart(restart || wr_iv || wr_tb),
    .second_tick(second_tick),
    .minute_tick(minute_tick)
  );

  // seconds when bit 7 set, minutes otherwise
  assign unit_tick = time_base_reg[`TB_SECONDS_BIT] ? second_tick : minute_tick;

  // =====================================
  // registers
  always @(posedge clock) begin
    if (rst) begin
      time_base_reg <= `TIME_BASE_RESET;
      interval_reg <= `INTERVAL_RESET;
      config_reg <= `CONFIG_RESET;
      key_end_en_reg <= 1'b0;
    end else begin
      if (wr_tb) begin
        time_base_reg <= {io_wdata[7], 5'h00, io_wdata[1:0]};
      end
      if (wr_iv) begin
        interval_reg <= io_wdata;
      end
      if (wr_cfg) begin
        // bits other than 2:1 forced to zero
        config_reg <= {4'h0, 1'b0, io_wdata[2:1], 1'b0};
      end
      if (wr_ctrl) begin
        key_end_en_reg <= io_wdata[`CTRL_KBD_END_BIT];
      end
    end
  end

  // =====================================
  // count state machine
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      count_reg <= 8'h00;
      expired_reg <= 1'b0;
      pulse_reg <= 5'h00;
      system_reset_out <= 1'b0;
    end else begin
      if (pulse_reg != 5'h00) begin
        pulse_reg <= pulse_reg - 5'h01;
        system_reset_out <= 1'b1;
      end else begin
        system_reset_out <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (wr_iv && io_wdata != 8'h00) begin
            count_reg <= io_wdata;
            expired_reg <= 1'b0;
            state_reg <= ST_COUNT;
          end else if (force_end) begin
            expired_reg <= 1'b1;
            pulse_reg <= `RESET_PULSE_CYCLES;
            state_reg <= ST_EXPIRED;
          end
        end
        ST_COUNT: begin
          if (force_end || key_end ||
              (unit_tick && count_reg == 8'h01 && !wr_iv && !restart)) begin
            expired_reg <= 1'b1;
            pulse_reg <= `RESET_PULSE_CYCLES;
            state_reg <= ST_EXPIRED;
          end else if (wr_iv) begin
            if (io_wdata == 8'h00) begin
              state_reg <= ST_IDLE;
            end else begin
              count_reg <= io_wdata;
            end
          end else if (restart) begin
            count_reg <= interval_reg;
          end else if (unit_tick) begin
            count_reg <= count_reg - 8'h01;
          end
        end
        ST_EXPIRED: begin
          if (wr_iv && io_wdata != 8'h00) begin
            count_reg <= io_wdata;
            expired_reg <= 1'b0;
            state_reg <= ST_COUNT;
          end else if (wr_iv) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign expired = expired_reg;

  // =====================================
  // read path
  always @(posedge clock) begin
    if (rst) begin
      io_rdata <= 8'h00;
      io_hit <= 1'b0;
    end else begin
      io_hit <= 1'b0;
      if (io_read) begin
        io_hit <= 1'b1;
        case (io_addr)
          `ADDR_TIME_BASE_SELECT: io_rdata <= time_base_reg;
          `ADDR_TIMEOUT_INTERVAL: io_rdata <= interval_reg;
          `ADDR_RESTART_SOURCE_CONFIG: io_rdata <= config_reg;
          `ADDR_TIMER_CONTROL_STATUS: begin
            io_rdata <= {4'h0, key_end_en_reg, 2'b00, expired_reg};
          end
          default: begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// File: testbench/programmable_watchdog_chk.sv
module programmable_watchdog_chk (
  input wire clock,
  input wire rst,
  input wire [15:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_write,
  input wire io_read,
  input wire [7:0] io_rdata,
  input wire io_hit,
  input wire kbd_irq,
  input wire mouse_irq,
  input wire key_press,
  input wire system_reset_out,
  input wire expired
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire map = io_addr >= 16'h0a65 && io_addr <= 16'h0a68;
  wire wr_ival = io_write && io_addr == 16'h0a66;
  wire force_wr = io_write && io_addr == 16'h0a68 && io_wdata[2];
  // high while interval zero and nothing forced
  reg off_reg;
  always @(posedge clock) begin
    if (force_wr) off_reg <= 1'b0;
    else if (rst) off_reg <= 1'b1;
    else if (wr_ival) off_reg <= io_wdata == 8'h00;
  end
  a_hit_mapped: assert property (io_read && map |=> io_hit) else $error("no hit");
  a_miss_quiet: assert property (io_read && !map |=> !io_hit && io_rdata == 8'h00)
    else $error("unmapped answered");
  a_status_read: assert property (io_read && io_addr == 16'h0a68 |=>
    io_rdata[0] == $past(expired)) else $error("status bit wrong");
  a_force_fires: assert property (force_wr |-> ##[1:3] expired) else $error("no force");
  a_zero_silent: assert property (off_reg |-> !$rose(expired)) else $error("idle expiry");
  a_reload_clears: assert property (wr_ival && io_wdata != 8'h00 |-> ##[1:2] !expired)
    else $error("reload kept flag");
  a_flag_latched: assert property (expired && !io_write |=> expired) else $error("flag lost");
  a_pulse_width: assert property ($rose(system_reset_out) |-> system_reset_out[*8])
    else $error("pulse short");
  a_pulse_cause: assert property ($rose(expired) |-> ##[0:2] system_reset_out)
    else $error("no pulse");
  cover property ($rose(expired));
  cover property ($rose(system_reset_out));
  cover property (io_read && !map);
endmodule

bind programmable_watchdog programmable_watchdog_chk programmable_watchdog_chk_i (
  .clock(clock), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
  .io_read(io_read), .io_rdata(io_rdata), .io_hit(io_hit), .kbd_irq(kbd_irq),
  .mouse_irq(mouse_irq), .key_press(key_press), .system_reset_out(system_reset_out),
  .expired(expired));

// File: testbench/programmable_watchdog_bench.sv
module programmable_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, sn); end end
  logic clock = 0, rst = 1, io_write = 0, io_read = 0, rd_d = 0;
  logic kbd_irq = 0, mouse_irq = 0, key_press = 0;
  logic [15:0] io_addr = 0;
  logic [7:0] io_wdata = 0, r;
  logic [8:0] q;
  logic [8:0] expq[$];
  logic [31:0] seed = 32'hba06;
  int num_errors = 0, compares = 0, cyc = 0, n;
  wire [7:0] io_rdata;
  wire io_hit, system_reset_out, expired;
  programmable_watchdog #(.SECOND_CYCLES(24'h00_000a)) programmable_watchdog_i (
    .clock(clock), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
    .io_read(io_read), .io_rdata(io_rdata), .io_hit(io_hit), .kbd_irq(kbd_irq),
    .mouse_irq(mouse_irq), .key_press(key_press), .system_reset_out(system_reset_out),
    .expired(expired));
  initial forever #50 clock = ~clock;
  // ==========
  // tasks
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_write <= 1;
    @(posedge clock);
    io_write <= 0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    expq.push_back({a >= 16'h0a65 && a <= 16'h0a68, e});
    @(posedge clock);
    io_addr <= a;
    io_read <= 1;
    @(posedge clock);
    io_read <= 0;
  endtask
  task automatic flag(logic e);
    @(negedge clock);
    `CHK("expired", e, expired)
  endtask
  task automatic timed(logic [7:0] tb, logic [7:0] iv, int lo);
    wr(16'h0a65, tb);
    wr(16'h0a66, iv);
    @(negedge clock);
    n = 1;
    while (expired !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHK("expiry", 1'b1, n >= lo - 2 && n <= lo + 3)
    n = 0;
    repeat (4) if (system_reset_out !== 1'b1) @(negedge clock);
    while (system_reset_out === 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    `CHK("pulse", 16, n)
    rd(16'h0a68, 8'h01);
    $display("timed %0d done", lo);
  endtask
  // s: 0 keyboard irq, 1 mouse irq, 2 key press
  task automatic src(int s, logic [7:0] cfg, logic [7:0] ctl, logic e1, logic e2);
    wr(16'h0a65, 8'h80);
    wr(16'h0a67, cfg);
    wr(16'h0a68, ctl);
    wr(16'h0a66, 8'h05);
    step(28);
    if (s == 0) kbd_irq <= 1;
    else if (s == 1) mouse_irq <= 1;
    else key_press <= 1;
    step(2);
    {kbd_irq, mouse_irq, key_press} <= 3'b000;
    step(8);
    flag(e1);
    step(15);
    flag(e2);
    $display("source %0d done", s);
  endtask
  // ==========
  // checking and timeout
  always @(posedge clock) begin
    rd_d <= io_read;
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      num_errors++;
      complete_run();
    end
  end
  always @(negedge clock) begin
    if (rd_d) begin
      q = expq.pop_front();
      `CHK("read", q, {io_hit, io_rdata})
    end
  end
  initial begin
    step(4);
    rst <= 0;
    for (int a = 16'h0a65; a <= 16'h0a69; a++) rd(a[15:0], 8'h00);
    repeat (4) begin
      r = seed[7:0];
      seed = lfsr(seed);
      wr(16'h0a65, r);
      rd(16'h0a65, {r[7], 5'b0, r[1:0]});
      wr(16'h0a67, r & 8'h0f);
      rd(16'h0a67, r & 8'h06);
    end
    wr(16'h0a68, 8'h08);
    rd(16'h0a68, 8'h08);
    wr(16'h0a68, 8'h00);
    $display("registers done");
    timed(8'h80, 8'h03, 30);
    timed(8'h00, 8'h01, 600);
    timed(8'h80, 8'hff, 2550);
    src(0, 8'h02, 8'h00, 0, 0);
    src(0, 8'h04, 8'h00, 0, 1);
    src(1, 8'h04, 8'h00, 0, 0);
    src(1, 8'h02, 8'h00, 0, 1);
    src(2, 8'h00, 8'h08, 1, 1);
    src(2, 8'h06, 8'h00, 0, 1);
    wr(16'h0a66, 8'h05);
    wr(16'h0a66, 8'h00);
    step(80);
    flag(0);
    wr(16'h0a68, 8'h04);
    step(3);
    flag(1);
    $display("idle and force done");
    step(30);
    complete_run();
  end
endmodule
